// ---- src/pei_debounce.sv ----
// Stability filter for one source level on the slow tick
`default_nettype none

module pei_debounce (
	input  wire logic                        clk,
	input  wire logic                        rst,
	input  wire logic                        tick,
	input  wire logic                        level,
	input  wire logic [pei_pkg::TICK_W-1:0] riseTicks,
	input  wire logic [pei_pkg::TICK_W-1:0] fallTicks,
	output var  logic                        stableOut
);
	import pei_pkg::*;

	// ========================================================================
	// State
	typedef struct packed {
		logic [TICK_W-1:0] cnt;    // Ticks the new level has held
		logic              stable; // Accepted level
	} pei_deb_state_t;

	pei_deb_state_t    st;
	pei_deb_state_t    nx;
	logic [TICK_W-1:0] thr;        // Length for the pending direction

	// Any return to the accepted level restarts the count from zero
	always_comb begin
		nx  = st;
		thr = level ? riseTicks : fallTicks;
		if (level == st.stable) begin
			nx.cnt = '0;
		end else if (tick) begin
			if (st.cnt + 1'b1 >= thr) begin
				nx.stable = level;
				nx.cnt    = '0;
			end else begin
				nx.cnt = st.cnt + 1'b1;
			end
		end
	end

	// Register the state
	always_ff @(posedge clk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= nx;
		end
	end

	assign stableOut = st.stable;

	// ========================================================================
	// Checks
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	property p_deb_accept;
		$changed(st.stable) |-> $past(tick) && ($past(level) == st.stable) && ($past(st.cnt) + 1'b1 >= $past(thr));
	endproperty
	a_deb_accept: assert property (p_deb_accept) else $error("level accepted before its period");

	property p_deb_restart;
		(level == st.stable) |=> (st.cnt == '0);
	endproperty
	a_deb_restart: assert property (p_deb_restart) else $error("count not restarted");

endmodule // pei_debounce

`default_nettype wire

// ---- src/pei_event_irq.sv ----
// Event latch, mask, sense and interrupt output with an AXI4-Lite register slave
`default_nettype none

module pei_event_irq #(
	parameter int TICK_DIV = pei_pkg::TICK_DIV_DEFAULT  // Clock cycles per slow tick
) (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire pei_pkg::pei_axi_req_t axiReq,
	output var  pei_pkg::pei_axi_rsp_t axiRsp,
	input  wire pei_pkg::pei_src_t     srcPins,
	output var  logic                  irqOut
);
	import pei_pkg::*;

	// ========================================================================
	// State of the whole block
	typedef struct packed {
		pei_src_t          syncA;   // First synchroniser stage
		pei_src_t          syncB;   // Second synchroniser stage
		logic [DIV_W-1:0]  divCnt;  // Slow tick divider
		logic              tick;    // One cycle per slow period
		logic [EVT_N-1:0]  prevLvl; // Qualified levels one cycle ago
		logic [EVT_N-1:0]  status;  // Latched events
		logic [EVT_N-1:0]  mask;    // One blocks the interrupt
		logic [5:0]        btnCfg;  // button_fall_filter_sel, two bits per button
		logic              awHeld;  // Write address taken
		logic [ADDR_W-1:0] awAddr;
		logic              wHeld;   // Write data taken
		logic [31:0]       wData;
		logic [3:0]        wStrb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
		logic              irq;     // Registered interrupt line
	} pei_state_t;

	pei_state_t        st;          // Current state
	pei_state_t        nx;          // Next state
	logic [EVT_N-1:0]  srcLvl;      // Synchronised levels by event bit
	logic [EVT_N-1:0]  lvl;         // Qualified (debounced where needed) levels
	logic [EVT_N-1:0]  setVec;      // Events latching this cycle
	logic [EVT_N-1:0]  clrVec;      // Bits cleared by software this cycle
	logic              chgActLvl;   // Filtered charger_active_sense
	logic              awReady;
	logic              wReady;
	logic              doWrite;
	logic [31:0]       senseWord;
	logic [31:0]       auxWord;
	logic [31:0]       wMask;       // Held write strobes widened to bits

	// Write strobes to a bit mask; used for the status and mask registers
	function automatic logic [31:0] byteMask(input logic [3:0] strb);
		logic [31:0] m;
		m = '0;
		for (int b = 0; b < 4; b++) begin
			m[8*b +: 8] = {8{strb[b]}};
		end
		return m;
	endfunction

	// ========================================================================
	// Source levels: charger fault presence is any non-zero code
	always_comb begin
		srcLvl                = st.syncB.evtRaw;
		srcLvl[EVT_CHG_FAULT] = |st.syncB.faultCode;
	end

	// Debounce the external sources, pass internal ones straight through
	genvar gi;
	for (gi = 0; gi < EVT_N; gi++) begin : g_src
		if (DEB_MASK[gi]) begin : g_deb
			logic [TICK_W-1:0] fallT;                    // Falling candidate length
			if (gi >= EVT_BUTTON1 && gi < EVT_BUTTON1 + 3) begin : g_btn
				// Fall filter stretched by the per-button select
				assign fallT = ticksFor(gi, 1'b0)
					+ TICK_W'(st.btnCfg[2*(gi-EVT_BUTTON1) +: 2]) * TICKS_BTN_EXT;
			end else begin : g_fix
				assign fallT = ticksFor(gi, 1'b0);
			end
			pei_debounce u_deb (
				.clk       (clk),
				.rst       (rst),
				.tick      (st.tick),
				.level     (srcLvl[gi]),
				.riseTicks (ticksFor(gi, 1'b1)),
				.fallTicks (fallT),
				.stableOut (lvl[gi])
			);
		end else begin : g_raw
			// Internal completions and clock change carry no filter
			assign lvl[gi] = srcLvl[gi];
		end
	end

	// Charger activity has a sense only, filtered for a long period
	pei_debounce u_chg_act (
		.clk       (clk),
		.rst       (rst),
		.tick      (st.tick),
		.level     (st.syncB.chargerActive),
		.riseTicks (TICKS_CHG_ACT),
		.fallTicks (TICKS_CHG_ACT),
		.stableOut (chgActLvl)
	);

	// ========================================================================
	// Readable words; sense follows the live qualified level
	assign senseWord = {2'h0, lvl & SENSE_VALID};
	assign auxWord   = {24'h0, chgActLvl, st.syncB.chargePath, st.syncB.powerupStrap,
		st.syncB.modeStrap, st.syncB.faultCode};

	// Edge qualification per source
	assign setVec = (RISE_EN & lvl & ~st.prevLvl) | (FALL_EN & ~lvl & st.prevLvl);

	// Handshakes: one write and one read in flight, answer must drain first
	assign awReady = !st.awHeld && !st.bvalid;
	assign wReady  = !st.wHeld && !st.bvalid;
	assign doWrite = st.awHeld && st.wHeld && !st.bvalid;
	assign wMask   = byteMask(st.wStrb);

	// ========================================================================
	// Next-state logic
	always_comb begin
		nx     = st;
		clrVec = '0;

		// Two-stage synchroniser for every pin
		nx.syncA = srcPins;
		nx.syncB = st.syncA;

		// Slow tick divider
		if (st.divCnt == DIV_W'(TICK_DIV - 1)) begin
			nx.divCnt = '0;
			nx.tick   = 1'b1;
		end else begin
			nx.divCnt = st.divCnt + 1'b1;
			nx.tick   = 1'b0;
		end

		nx.prevLvl = lvl;

		// Write address and data may arrive in either order
		if (axiReq.awvalid && awReady) begin
			nx.awHeld = 1'b1;
			nx.awAddr = axiReq.awaddr;
		end
		if (axiReq.wvalid && wReady) begin
			nx.wHeld = 1'b1;
			nx.wData = axiReq.wdata;
			nx.wStrb = axiReq.wstrb;
		end

		// Perform the write once both halves are held
		if (doWrite) begin
			nx.awHeld = 1'b0;
			nx.wHeld  = 1'b0;
			nx.bvalid = 1'b1;
			nx.bresp  = RESP_OKAY;
			case (st.awAddr)
				OFF_STATUS: begin
					// Ones clear, zeros leave bits alone
					clrVec = st.wData[EVT_N-1:0] & wMask[EVT_N-1:0];
				end
				OFF_MASK: begin
					nx.mask = (st.mask & ~wMask[EVT_N-1:0])
						| (st.wData[EVT_N-1:0] & wMask[EVT_N-1:0]);
				end
				OFF_BTNCFG: begin
					if (st.wStrb[0]) begin
						nx.btnCfg = st.wData[5:0];
					end
				end
				OFF_SENSE, OFF_AUX: begin
					// Read-only words ignore writes
					nx.bresp = RESP_OKAY;
				end
				default: begin
					nx.bresp = RESP_DECERR;              // Unmapped
				end
			endcase
		end
		if (st.bvalid && axiReq.bready) begin
			nx.bvalid = 1'b0;
		end

		// Reads answer one cycle after the address is taken
		if (st.rvalid && axiReq.rready) begin
			nx.rvalid = 1'b0;
		end
		if (axiReq.arvalid && !st.rvalid) begin
			nx.rvalid = 1'b1;
			nx.rresp  = RESP_OKAY;
			case (axiReq.araddr)
				OFF_STATUS: nx.rdata = {2'h0, st.status};
				OFF_MASK:   nx.rdata = {2'h0, st.mask};
				OFF_SENSE:  nx.rdata = senseWord;
				OFF_AUX:    nx.rdata = auxWord;
				OFF_BTNCFG: nx.rdata = {26'h0, st.btnCfg};
				default: begin
					nx.rdata = '0;
					nx.rresp = RESP_DECERR;
				end
			endcase
		end

		// Set wins over a clear in the same cycle; mask never stops latching
		nx.status = (st.status & ~clrVec) | setVec;

		// Masked OR, taken from the next state so it tracks status exactly
		nx.irq = |(nx.status & ~nx.mask);
	end

	// ========================================================================
	// State register; low-power boot starts unmasked
	always_ff @(posedge clk) begin
		if (rst) begin
			st      <= '0;
			st.mask <= MASK_RESET;
		end else begin
			st <= nx;
		end
	end

	// ========================================================================
	// Outputs
	always_comb begin
		axiRsp.awready = awReady;
		axiRsp.wready  = wReady;
		axiRsp.bvalid  = st.bvalid;
		axiRsp.bresp   = st.bresp;
		axiRsp.arready = !st.rvalid;
		axiRsp.rvalid  = st.rvalid;
		axiRsp.rdata   = st.rdata;
		axiRsp.rresp   = st.rresp;
	end

	assign irqOut = st.irq;                              // Same line for either host link

	// ========================================================================
	// Checks
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// Line follows the masked OR of the registered state
	property p_irq_or;
		irqOut == |(st.status & ~st.mask);
	endproperty
	a_irq_or: assert property (p_irq_or) else $error("interrupt is not the masked OR");

	// Only a clear may drop a latched bit
	property p_hold;
		(($past(st.status) & ~$past(clrVec)) & ~st.status) == '0;
	endproperty
	a_hold: assert property (p_hold) else $error("status bit dropped without a clear");

	// A clear with no coinciding event empties the bit
	property p_clear;
		|($past(clrVec) & ~$past(setVec) & st.status) == 1'b0;
	endproperty
	a_clear: assert property (p_clear) else $error("cleared bit still set");

	// An event in the cycle of a clear survives it
	property p_set_wins;
		($past(setVec) & ~st.status) == '0;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost during a clear");

	// Nothing unmasked pending means a quiet line
	property p_masked_quiet;
		((st.status & ~st.mask) == '0) |-> !irqOut;
	endproperty
	a_masked_quiet: assert property (p_masked_quiet) else $error("masked bit raised the line");

	// Mask gates only the line, never the latch
	property p_masked_latch;
		|(setVec & st.mask) |=> |($past(setVec) & $past(st.mask) & st.status);
	endproperty
	a_masked_latch: assert property (p_masked_latch) else $error("masked event not latched");

	// Must look during reset, so the default disable is overridden
	property p_reset_mask;
		@(posedge clk) disable iff (1'b0) rst |=> (st.mask == MASK_RESET) && !irqOut;
	endproperty
	a_reset_mask: assert property (p_reset_mask) else $error("wrong mask after reset");

	// Unmasking a pending bit raises the line with no new event
	property p_unmask;
		|(st.status & $past(st.mask) & ~st.mask) |-> irqOut;
	endproperty
	a_unmask: assert property (p_unmask) else $error("unmasking did not raise the line");

	// Sense reads return the live level of the address cycle
	property p_sense_read;
		(axiReq.arvalid && !st.rvalid && axiReq.araddr == OFF_SENSE) |=> st.rvalid && st.rdata == $past(senseWord);
	endproperty
	a_sense_read: assert property (p_sense_read) else $error("sense read not live");

	// Unfiltered sources latch one cycle after their synchronised rise
	property p_raw_latch;
		((st.syncB.evtRaw & ~$past(st.syncB.evtRaw) & ~DEB_MASK) != '0)
			|=> (($past(st.syncB.evtRaw) & ~$past(st.syncB.evtRaw, 2) & ~DEB_MASK & ~st.status) == '0);
	endproperty
	a_raw_latch: assert property (p_raw_latch) else $error("internal event not latched at once");

	// Write answer and its code stand until the master takes them
	property p_b_stands;
		(st.bvalid && !axiReq.bready) |=> st.bvalid && $stable(st.bresp);
	endproperty
	a_b_stands: assert property (p_b_stands) else $error("write answer dropped early");

	// Read data stands until the master takes it
	property p_r_stands;
		(st.rvalid && !axiReq.rready) |=> st.rvalid && $stable(st.rdata);
	endproperty
	a_r_stands: assert property (p_r_stands) else $error("read answer dropped early");

	// No write half is taken while an answer waits
	property p_refuse;
		st.bvalid |-> !axiRsp.awready && !axiRsp.wready;
	endproperty
	a_refuse: assert property (p_refuse) else $error("write taken while answer pending");

	// Both halves held: the write is performed this cycle
	sequence s_both_held;
		st.awHeld && st.wHeld && !st.bvalid;
	endsequence

	// Answer rises, then stays unless the master took it
	sequence s_answer;
		st.bvalid ##1 (st.bvalid || $past(axiReq.bready));
	endsequence

	property p_write_answer;
		s_both_held |=> s_answer;
	endproperty
	a_write_answer: assert property (p_write_answer) else $error("write not answered");

endmodule // pei_event_irq

`default_nettype wire

// ---- src/pei_pkg.sv ----
// Constants, types and source tables of the event interrupt unit
// ============================================================================
// Overview of operation
// - Unmasked pending event drives interrupt output high
// - Status bits latch and hold until cleared
// - Writing one clears a status bit
// - New event during a clear keeps output high
// - Mask bit one blocks its status bit
// - Masked status bits still latch and read
// - Reset masks everything except low-power boot
// - Unmasking a set bit raises output at once
// - Sense bits are live, read-only, never latched
// - External events latch only after stable debounce
// - Internal completion events latch on rise, undebounced
// - Charger detect both edges 32 ms; active 100 ms
// - Charger fault rises after 10 ms; two-bit code
// - Charge current latches on fall after 1 ms
// - Session valid: rise 24 ms, fall 12 ms
// - Identification pin events both edges after 90 us
// - Thermal warnings both edges after 30 ms
// - Buttons both edges 30 ms, fall extendable
// - Oscillator change both edges, no debounce
// - Low battery rise undebounced; battery-on 30 ms
// - Strap codes and charge path readable as sense
`default_nettype none

package pei_pkg;

	// ========================================================================
	// Bus and register map
	localparam int          ADDR_W      = 8;             // Byte address width
	localparam int          EVT_N       = 30;            // Event sources
	localparam logic [7:0]  OFF_STATUS  = 8'h00;         // Latched events, write one to clear
	localparam logic [7:0]  OFF_MASK    = 8'h04;         // One blocks the interrupt
	localparam logic [7:0]  OFF_SENSE   = 8'h08;         // Live source levels
	localparam logic [7:0]  OFF_AUX     = 8'h0c;         // Fault code, straps, path
	localparam logic [7:0]  OFF_BTNCFG  = 8'h10;         // Button fall filter selects
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_DECERR = 2'h3;
	localparam logic [29:0] MASK_RESET  = 30'h1fffffff;  // All masked but low-power boot

	// ========================================================================
	// Event bit positions
	localparam int EVT_CHG_FAULT = 5;
	localparam int EVT_BUTTON1   = 17;
	localparam int EVT_LP_BOOT   = 29;

	// Per-bit qualification tables
	localparam logic [29:0] DEB_MASK    = 30'h380e3efc;  // Debounced external sources
	localparam logic [29:0] RISE_EN     = 30'h3fffffbf;  // Rising edge latches
	localparam logic [29:0] FALL_EN     = 30'h3a0e3e5c;  // Falling edge latches
	localparam logic [29:0] SENSE_VALID = 30'h3a0e3fd8;  // Bits with a live sense

	// ========================================================================
	// Timebase: the slow tick stands in for the 32 kHz control clock
	localparam int CLK_HZ           = 250000000;
	localparam int SLOW_HZ          = 32768;
	localparam int TICK_DIV_DEFAULT = CLK_HZ / SLOW_HZ;  // Clock cycles per slow tick
	localparam int DIV_W            = 13;
	localparam int TICK_W           = 16;

	// Debounce periods in microseconds, as printed
	localparam int T_CHG_DET_US  = 32000;
	localparam int T_CHG_ACT_US  = 100000;
	localparam int T_FAULT_US    = 10000;
	localparam int T_CURR_US     = 1000;
	localparam int T_SESS_R_US   = 24000;
	localparam int T_SESS_F_US   = 12000;
	localparam int T_ID_US       = 90;
	localparam int T_30MS_US     = 30000;
	localparam int T_OVOLT_US    = 60;
	localparam int T_LPB_US      = 1000;
	localparam int BTN_STEP_US   = 30000;                // Added per step of the fall select

	// Least time to whole slow ticks, rounded up, never below one
	function automatic logic [15:0] ticksFromUs(input int us);
		int t;
		t = (us * 4096 + 124999) / 125000;
		return (t < 1) ? 16'h0001 : t[15:0];
	endfunction

	localparam logic [15:0] TICKS_CHG_ACT = ticksFromUs(T_CHG_ACT_US);
	localparam logic [15:0] TICKS_BTN_EXT = ticksFromUs(BTN_STEP_US);

	// Debounce length of one source for its rising or falling candidate
	function automatic logic [15:0] ticksFor(input int bitIdx, input logic rise);
		case (bitIdx)
			3:               return ticksFromUs(T_CHG_DET_US);
			4:               return ticksFromUs(T_OVOLT_US);
			5:               return ticksFromUs(T_FAULT_US);
			6:               return ticksFromUs(T_CURR_US);
			9, 10:           return ticksFromUs(rise ? T_SESS_R_US : T_SESS_F_US);
			11, 12, 13:      return ticksFromUs(T_ID_US);
			29:              return ticksFromUs(T_LPB_US);
			default:         return ticksFromUs(T_30MS_US);
		endcase
	endfunction

	// ========================================================================
	// Carriers
	typedef struct packed {
		logic [29:0] evtRaw;        // Source levels by event bit
		logic [1:0]  faultCode;     // charger_fault_code
		logic        chargerActive; // Unfiltered charger_active_sense
		logic [1:0]  modeStrap;     // mode_strap_sense
		logic [1:0]  powerupStrap;  // powerup_strap_sense
		logic        chargePath;    // charge_path_sense
	} pei_src_t;

	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} pei_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} pei_axi_rsp_t;

endpackage

`default_nettype wire

// ---- tb/pei_event_irq_tb_top.sv ----
// Self-checking bench for the event interrupt unit over its register bus
`default_nettype none

module pei_event_irq_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import pei_pkg::*;

	// ========================================================================
	// Signals
	localparam int TDIV = 4;      // Short slow tick keeps debounce runs brief
	logic         clk;            // 250 MHz bench clock
	logic         rst;            // Synchronous reset, active high
	logic         irqOut;         // Interrupt line to the processor
	pei_axi_req_t axiReq;         // Bus requests from the bench
	pei_axi_rsp_t axiRsp;         // Bus answers from the unit
	pei_src_t     levels;         // Wanted source levels
	pei_src_t     srcPins;        // Source levels at the unit
	int           bad_count;      // Mismatches seen
	int           compares;       // Comparisons made
	logic [1:0]   rs;             // Last response code
	logic [31:0]  rd;             // Last read data

	pei_event_irq #(.TICK_DIV(TDIV)) pei_event_irq_i (.clk(clk), .rst(rst), .axiReq(axiReq), .axiRsp(axiRsp),
		.srcPins(srcPins), .irqOut(irqOut));
	pei_src_model pei_src_model_i (.clk(clk), .levels(levels), .srcPins(srcPins));

	// Free-running clock, 4 ns period
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// ========================================================================
	// Reporting
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// ========================================================================
	// Bus tasks
	// Polls at the falling edge, so the value seen is what the next rising edge takes
	task automatic waitRsp(input int which);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (!(which == 0 ? axiRsp.bvalid : which == 1 ? axiRsp.arready : axiRsp.rvalid) && n < 100);
		if (n >= 100) begin
			bad_count++;
			$display("MISMATCH handshake expected answer seen timeout");
			end_of_test();
		end
	endtask

	// Address and data offered together; each released once taken
	task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
		logic awPend;
		logic wPend;
		logic awT;
		logic wT;
		int   n;
		awPend = 1'b1;
		wPend = 1'b1;
		n = 0;
		@(posedge clk);
		axiReq.awvalid <= 1'b1;
		axiReq.awaddr <= a;
		axiReq.wvalid <= 1'b1;
		axiReq.wdata <= d;
		axiReq.wstrb <= 4'hf;
		axiReq.bready <= 1'b1;
		while ((awPend || wPend) && n < 100) begin
			@(negedge clk);
			awT = awPend && axiRsp.awready;
			wT = wPend && axiRsp.wready;
			@(posedge clk);
			if (awT) begin
				awPend = 1'b0;
				axiReq.awvalid <= 1'b0;
			end
			if (wT) begin
				wPend = 1'b0;
				axiReq.wvalid <= 1'b0;
			end
			n++;
		end
		if (awPend || wPend) begin
			bad_count++;
			$display("MISMATCH write handshake expected taken seen timeout");
			end_of_test();
		end
		waitRsp(0);
		resp = axiRsp.bresp;
		@(posedge clk);
		axiReq.bready <= 1'b0;
	endtask

	task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		@(posedge clk);
		axiReq.arvalid <= 1'b1;
		axiReq.araddr <= a;
		axiReq.rready <= 1'b1;
		waitRsp(1);
		@(posedge clk);
		axiReq.arvalid <= 1'b0;
		waitRsp(2);
		d = axiRsp.rdata;
		resp = axiRsp.rresp;
		@(posedge clk);
		axiReq.rready <= 1'b0;
	endtask

	task automatic expectReg(input logic [7:0] a, input logic [31:0] exp, input string what);
		logic [31:0] d;
		logic [1:0]  r;
		axiRead(a, d, r);
		check(what, d, exp);
	endtask

	// Sampled mid-cycle, away from the edge that updates it
	task automatic expectIrq(input logic exp, input string what);
		@(negedge clk);
		check(what, {31'h0, irqOut}, {31'h0, exp});
	endtask

	// Moves one source pin, then lets time pass
	task automatic setPin(input int idx, input logic v, input int waitCyc);
		@(posedge clk);
		levels.evtRaw[idx] <= v;
		repeat (waitCyc) @(posedge clk);
	endtask

	// ========================================================================
	// Main sequence
	initial begin
		rst = 1'b1;
		axiReq = '0;
		levels = '0;
		bad_count = 0;
		compares = 0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		// Reset state and an unmapped address
		expectReg(OFF_MASK, {2'h0, MASK_RESET}, "mask reset");
		expectReg(OFF_STATUS, 32'h00000000, "status reset");
		expectIrq(1'b0, "irq reset");
		axiRead(8'h14, rd, rs);
		check("unmapped read", rd, 32'h00000000);
		check("unmapped read resp", {30'h0, rs}, {30'h0, RESP_DECERR});
		axiWrite(8'h14, 32'hffffffff, rs);
		check("unmapped write resp", {30'h0, rs}, {30'h0, RESP_DECERR});
		$display("test reset done");
		// Undebounced rise latch, mask, unmask, clear
		setPin(0, 1'b1, 3);
		setPin(0, 1'b0, 10);
		expectReg(OFF_STATUS, 32'h00000001, "conv done latched");
		expectIrq(1'b0, "irq while masked");
		axiWrite(OFF_MASK, 32'h1ffffffe, rs);
		check("mask write resp", {30'h0, rs}, {30'h0, RESP_OKAY});
		expectIrq(1'b1, "irq on unmask");
		axiWrite(OFF_STATUS, 32'h00000000, rs);
		expectReg(OFF_STATUS, 32'h00000001, "zero write keeps");
		axiWrite(OFF_STATUS, 32'h00000001, rs);
		expectIrq(1'b0, "irq after clear");
		expectReg(OFF_STATUS, 32'h00000000, "status cleared");
		$display("test latch done");
		// Oscillator change: both edges, live sense untouched by clears
		setPin(25, 1'b1, 10);
		expectReg(OFF_SENSE, 32'h02000000, "osc sense high");
		expectReg(OFF_STATUS, 32'h02000000, "osc rise");
		axiWrite(OFF_STATUS, 32'h02000000, rs);
		expectReg(OFF_SENSE, 32'h02000000, "sense after clear");
		setPin(25, 1'b0, 10);
		expectReg(OFF_STATUS, 32'h02000000, "osc fall");
		axiWrite(OFF_STATUS, 32'h02000000, rs);
		axiWrite(OFF_SENSE, 32'hffffffff, rs);
		expectReg(OFF_SENSE, 32'h00000000, "sense read only");
		$display("test sense done");
		// Identification pin: short pulse rejected, full period accepted
		setPin(11, 1'b1, 2);
		setPin(11, 1'b0, 40);
		expectReg(OFF_STATUS, 32'h00000000, "short id pulse");
		setPin(11, 1'b1, 6);
		expectReg(OFF_STATUS, 32'h00000000, "id before period");
		repeat (40) @(posedge clk);
		expectReg(OFF_STATUS, 32'h00000800, "id open rise");
		expectReg(OFF_SENSE, 32'h00000800, "id open sense");
		axiWrite(OFF_STATUS, 32'h3fffffff, rs);
		setPin(11, 1'b0, 40);
		expectReg(OFF_STATUS, 32'h00000800, "id open fall");
		axiWrite(OFF_STATUS, 32'h3fffffff, rs);
		$display("test debounce done");
		// Charge current latches on the fall only, after 33 slow ticks
		setPin(6, 1'b1, 200);
		expectReg(OFF_STATUS, 32'h00000000, "current rise ignored");
		expectReg(OFF_SENSE, 32'h00000040, "current sense");
		setPin(6, 1'b0, 60);
		expectReg(OFF_STATUS, 32'h00000000, "current fall early");
		repeat (100) @(posedge clk);
		expectReg(OFF_STATUS, 32'h00000040, "current fall latched");
		axiWrite(OFF_STATUS, 32'h3fffffff, rs);
		$display("test current done");
		// Low-power boot is unmasked from reset
		axiWrite(OFF_MASK, {2'h0, MASK_RESET}, rs);
		setPin(29, 1'b1, 200);
		expectIrq(1'b1, "low power boot irq");
		axiWrite(OFF_STATUS, 32'h20000000, rs);
		expectIrq(1'b0, "low power boot cleared");
		$display("test boot done");
		// Button 1: 984 ticks to rise, fall stretched by one step to 1968
		axiWrite(OFF_BTNCFG, 32'h00000001, rs);
		setPin(17, 1'b1, 4000);
		expectReg(OFF_STATUS, 32'h00020000, "button rise");
		axiWrite(OFF_STATUS, 32'h3fffffff, rs);
		setPin(17, 1'b0, 4000);
		expectReg(OFF_STATUS, 32'h00000000, "button fall early");
		repeat (4000) @(posedge clk);
		expectReg(OFF_STATUS, 32'h00020000, "button fall stretched");
		axiWrite(OFF_STATUS, 32'h3fffffff, rs);
		$display("test button done");
		// Straps, fault code, charge path and button filter settings
		@(posedge clk);
		levels.faultCode <= 2'h2;
		levels.modeStrap <= 2'h3;
		levels.powerupStrap <= 2'h1;
		levels.chargePath <= 1'b1;
		repeat (6) @(posedge clk);
		expectReg(OFF_AUX, 32'h0000005e, "aux sense");
		axiWrite(OFF_BTNCFG, 32'hffffffff, rs);
		expectReg(OFF_BTNCFG, 32'h0000003f, "button filter select");
		$display("test sense fields done");
		end_of_test();
	end
endmodule // pei_event_irq_tb_top

`default_nettype wire

// ---- tb/pei_src_model.sv ----
// Behavioural model of the event sources that feed the interrupt unit
`default_nettype none

module pei_src_model (
	input  wire logic              clk,
	input  wire pei_pkg::pei_src_t levels,
	output var  pei_pkg::pei_src_t srcPins
);
	timeunit 1ns;
	timeprecision 1ps;
	import pei_pkg::*;

	// ========================================================================
	// Source levels
	// Start quiet so no event appears before the bench asks for one
	initial begin
		srcPins = '0;
	end

	// Sources move just after an edge, as comparators behind a flop would
	always @(posedge clk) begin
		srcPins <= levels;
	end
endmodule // pei_src_model

`default_nettype wire
